// File: enc_receiver_model.sv
// Host-side encoder receiver model that counts quadrature steps and index pulses.
`timescale 1ns/1ps
module enc_receiver_model (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        armed,
  input  wire logic        invert,
  input  wire logic        quadA,
  input  wire logic        quadB,
  input  wire logic        quadIndex,
  output logic      [15:0] stepCount,
  output logic      [15:0] badSteps,
  output logic      [15:0] lastGap,
  output logic      [15:0] indexRises
);
  logic [1:0]  phase;
  logic [1:0]  prevPhase;
  logic        prevIndex;
  logic [15:0] gapCount;

  //////////////////////////////////////////////////////////////////////////////
  // gray state decode
  // Undo the inversion, then number the states 00,01,11,10 as 0 to 3.
  assign phase = {quadA ^ invert, quadA ^ quadB};

  //////////////////////////////////////////////////////////////////////////////
  // ignore until armed
  // Levels and the gap timer run all along, but no step or index is counted before arming,
  // because the first seeding jump is not a real step.
  always @(posedge sys_clk) begin
    prevPhase <= phase;
    prevIndex <= quadIndex ^ invert;
    gapCount  <= gapCount + 16'h0001;
    if (rst) begin
      stepCount  <= 16'h0000;
      badSteps   <= 16'h0000;
      lastGap    <= 16'h0000;
      indexRises <= 16'h0000;
      gapCount   <= 16'h0000;
    end else if (armed) begin
      if (phase != prevPhase) begin
        gapCount <= 16'h0001;
        lastGap  <= gapCount;
        case (2'(phase - prevPhase))
          2'h1: stepCount <= stepCount + 16'h0001;
          2'h3: stepCount <= stepCount - 16'h0001;
          default: badSteps <= badSteps + 16'h0001; // Both lines moved at once.
        endcase
      end
      if ((quadIndex ^ invert) && !prevIndex) begin
        indexRises <= indexRises + 16'h0001;
      end
    end
  end
endmodule

// File: qenc_pkg.sv
// Shared constants and types for the quadrature encoder output block.
package qenc_pkg;

  // Widths of the register port, the angle samples and the output position.
  localparam int ADDR_W  = 8;
  localparam int DATA_W  = 32;
  localparam int ANGLE_W = 14;
  localparam int POS_W   = 13;
  localparam int TIMER_W = 8;

  typedef logic [POS_W-1:0]   pos_type;
  typedef logic [ANGLE_W-1:0] angle_type;

  // Register offsets at their printed positions.
  localparam logic [ADDR_W-1:0] OFF_CONFIG = 8'h19;
  localparam logic [ADDR_W-1:0] OFF_HYST   = 8'h17;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h20;

  // Field positions in the configuration word.
  localparam int RES_LSB     = 0;
  localparam int IDX_LSB     = 4;
  localparam int DIRREV_BIT  = 6;
  localparam int INV_BIT     = 7;
  localparam int HYSTEN_BIT  = 12;
  localparam int SLEW_LSB    = 16;
  // Field positions in the hysteresis and status words.
  localparam int HYSTWIN_LSB = 12;
  localparam int WARN_BIT    = 0;
  localparam int PRIMED_BIT  = 1;
  localparam int POSRD_LSB   = 16;

  // Resolution code limits and reset values.
  localparam logic [3:0] RES_MIN       = 4'h3;
  localparam logic [3:0] RES_MAX       = 4'he;
  localparam logic [3:0] RES_RESET     = 4'h3;
  localparam logic [1:0] IDX_RESET     = 2'h0;
  localparam logic [5:0] SLEW_RESET    = 6'h08;
  localparam logic [5:0] HYSTWIN_RESET = 6'h00;

  // Timing: core clock period and the slew interval unit, both in ns.
  localparam int CLK_PERIOD_NS = 50;
  localparam int SLEW_UNIT_NS  = 125;

endpackage

// File: quad_index_decode.sv
// Maps an output position to quadrature phase levels and the index level.
`timescale 1ns/1ps
module quad_index_decode (
  input  wire qenc_pkg::pos_type pos,
  input  wire qenc_pkg::pos_type mask,
  input  wire logic [1:0]        idxMode,
  output logic                   phaseA,
  output logic                   phaseB,
  output logic                   indexLevel
);

  qenc_pkg::pos_type width;

  // phase quarter lag.
  // Gray order 00, 01, 11, 10 keeps one phase change per state step.
  always_comb begin
    case (pos[1:0])
      2'h0: {phaseA, phaseB} = 2'b00;
      2'h1: {phaseA, phaseB} = 2'b01;
      2'h2: {phaseA, phaseB} = 2'b11;
      default: {phaseA, phaseB} = 2'b10;
    endcase
  end

  // width from index mode.
  // The width in states is clamped below one revolution so the pulse always falls.
  always_comb begin
    width = {11'h000, idxMode} + 13'h0001;
    if (width > mask) begin
      width = mask;
    end
  end

  // rising at zero.
  // A window starting at zero gives a rising edge there going up and a falling one going down.
  assign indexLevel = (pos < width);

endmodule

// File: quadrature_encoder_output.sv
// Quadrature and index encoder output generator with edge slew limiting.
`timescale 1ns/1ps
module quadrature_encoder_output (
  input  wire logic                            sys_clk,
  input  wire logic                            rst,
  input  wire logic                            clkEn,
  input  wire qenc_pkg::angle_type             rawAngle,
  input  wire qenc_pkg::angle_type             hystAngle,
  input  wire logic                            sampleValid,
  input  wire logic [qenc_pkg::ADDR_W-1:0]     regAddr,
  input  wire logic [qenc_pkg::DATA_W-1:0]     regWdata,
  input  wire logic                            regWrite,
  input  wire logic                            regRead,
  output logic      [qenc_pkg::DATA_W-1:0]     regRdata,
  output logic                                 quadA,
  output logic                                 quadB,
  output logic                                 quadIndex,
  output logic                                 hysteresisEnable,
  output logic      [5:0]                      hysteresisWindow,
  output logic                                 slew_limit_warning
);

  ////////////////////////////////////////////////////////////////////////////////
  // State and helper functions.

  typedef struct packed {
    logic [3:0]         resCode;
    logic [1:0]         idxMode;
    logic               direction_reverse;
    logic               output_invert;
    logic               hystEn;
    logic [5:0]         edge_slew_interval;
    logic [5:0]         hystWin;
    logic               warn;
    qenc_pkg::angle_type angle;
    logic               primed;
    qenc_pkg::pos_type  pos;
    logic               phaseA;
    logic               phaseB;
    logic               index;
    logic [31:0]        rdata;
  } core_state_type;

  core_state_type s;
  core_state_type next_s;

  // clamp resolution code.
  // Factory and unused codes fall back to the nearest customer code.
  function automatic logic [3:0] usableCode(input logic [3:0] c);
    if (c < qenc_pkg::RES_MIN) begin
      usableCode = qenc_pkg::RES_MIN;
    end else if (c > qenc_pkg::RES_MAX) begin
      usableCode = qenc_pkg::RES_MAX;
    end else begin
      usableCode = c;
    end
  endfunction

  // reverse angle sense.
  // The reported angle is negated modulo one turn, then scaled to the state count.
  function automatic qenc_pkg::pos_type targetOf(input qenc_pkg::angle_type a,
                                                 input logic [3:0] c,
                                                 input logic rev);
    qenc_pkg::angle_type r;
    r = rev ? (14'h0000 - a) : a;
    targetOf = qenc_pkg::pos_type'(r >> (usableCode(c) - 4'h2));
  endfunction

  // beyond sample period.
  // A least time, so the cycle count is rounded up; code 63 reaches 8 us.
  function automatic logic [qenc_pkg::TIMER_W-1:0] slewCycles(input logic [5:0] c);
    int ns;
    ns = qenc_pkg::SLEW_UNIT_NS * (int'(c) + 1);
    slewCycles = (qenc_pkg::TIMER_W)'((ns + qenc_pkg::CLK_PERIOD_NS - 1)
                                       / qenc_pkg::CLK_PERIOD_NS);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Position tracking and slew limiting.

  qenc_pkg::angle_type angleSel;
  qenc_pkg::pos_type   mask;
  qenc_pkg::pos_type   target;
  qenc_pkg::pos_type   targetIn;
  qenc_pkg::pos_type   diff;
  logic                backward;
  logic                singleStep;
  logic                slewOn;
  logic                timerDone;
  logic                stepPulse;
  logic                limiting;
  logic                decA;
  logic                decB;
  logic                decIndex;

  // back-fill hysteresis jumps.
  // The compensated angle jumps a whole window on reversal; the stepper below fills it in.
  assign angleSel = s.hystEn ? hystAngle : rawAngle;

  // Targets and the wrapped distance from the present output position.
  assign mask     = 13'h1fff >> (usableCode(s.resCode) - 4'h3);
  assign target   = targetOf(s.angle, s.resCode, s.direction_reverse);
  assign targetIn = targetOf(angleSel, s.resCode, s.direction_reverse);
  assign diff     = (target - s.pos) & mask;

  // wrapped direction sign.
  // A distance at or above half a turn is taken as the shorter way backwards.
  assign backward   = |(diff & ~(mask >> 1));
  assign singleStep = (diff == 13'h0001) || (diff == mask);

  assign slewOn = (s.edge_slew_interval != 6'h00);

  // one change per expiry.
  // A step is allowed only on an expired timer, and each step restarts it.
  assign stepPulse = clkEn && s.primed && slewOn && (diff != 13'h0000) && timerDone;

  // detect limiting.
  // Limiting means the output lags: a skipped state, or an edge that must wait.
  assign limiting = clkEn && s.primed && slewOn && (diff != 13'h0000)
                    && !(timerDone && singleStep);

  slew_timer u_slew_timer (
    .sys_clk      (sys_clk),
    .rst          (rst),
    .clkEn        (clkEn),
    .start        (stepPulse),
    .periodCycles (slewCycles(s.edge_slew_interval)),
    .done         (timerDone)
  );

  quad_index_decode u_quad_index_decode (
    .pos        (next_s.pos),
    .mask       (mask),
    .idxMode    (next_s.idxMode),
    .phaseA     (decA),
    .phaseB     (decB),
    .indexLevel (decIndex)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Next state.

  // Register port, sample capture and output stepping share one next-state process.
  always_comb begin
    next_s       = s;
    next_s.rdata = 32'h0000_0000;
    // Configuration writes; the status write clears the warning by writing one.
    if (regWrite) begin
      if (regAddr == qenc_pkg::OFF_CONFIG) begin
        next_s.resCode            = regWdata[qenc_pkg::RES_LSB +: 4];
        next_s.idxMode            = regWdata[qenc_pkg::IDX_LSB +: 2];
        next_s.direction_reverse  = regWdata[qenc_pkg::DIRREV_BIT];
        next_s.output_invert      = regWdata[qenc_pkg::INV_BIT];
        next_s.hystEn             = regWdata[qenc_pkg::HYSTEN_BIT];
        next_s.edge_slew_interval = regWdata[qenc_pkg::SLEW_LSB +: 6];
      end else if (regAddr == qenc_pkg::OFF_HYST) begin
        next_s.hystWin = regWdata[qenc_pkg::HYSTWIN_LSB +: 6];
      end else if (regAddr == qenc_pkg::OFF_STATUS) begin
        if (regWdata[qenc_pkg::WARN_BIT]) begin
          next_s.warn = 1'b0;
        end
      end
    end
    // Reads answer one cycle later; an unmapped address reads zero.
    if (regRead) begin
      if (regAddr == qenc_pkg::OFF_CONFIG) begin
        next_s.rdata[qenc_pkg::RES_LSB +: 4]  = s.resCode;
        next_s.rdata[qenc_pkg::IDX_LSB +: 2]  = s.idxMode;
        next_s.rdata[qenc_pkg::DIRREV_BIT]    = s.direction_reverse;
        next_s.rdata[qenc_pkg::INV_BIT]       = s.output_invert;
        next_s.rdata[qenc_pkg::HYSTEN_BIT]    = s.hystEn;
        next_s.rdata[qenc_pkg::SLEW_LSB +: 6] = s.edge_slew_interval;
      end else if (regAddr == qenc_pkg::OFF_HYST) begin
        next_s.rdata[qenc_pkg::HYSTWIN_LSB +: 6] = s.hystWin;
      end else if (regAddr == qenc_pkg::OFF_STATUS) begin
        next_s.rdata[qenc_pkg::WARN_BIT]          = s.warn;
        next_s.rdata[qenc_pkg::PRIMED_BIT]        = s.primed;
        next_s.rdata[qenc_pkg::POSRD_LSB +: 13]   = s.pos;
      end
    end
    // The latest sample is held so catch-up continues between samples.
    if (sampleValid) begin
      next_s.angle = angleSel;
    end
    // Drop position bits that a coarser resolution no longer uses, so the index
    // compare never sees stale high bits; a status read in the cycle right after the change can still return them.
    next_s.pos = s.pos & mask;
    if (!s.primed) begin
      if (sampleValid) begin
        next_s.pos    = targetIn;
        next_s.primed = 1'b1;
      end
    end else if (diff != 13'h0000) begin
      if (!slewOn) begin
        // Without limiting the output follows each sample at once.
        next_s.pos = target;
      end else if (stepPulse) begin
        if (backward) begin
          next_s.pos = (s.pos - 13'h0001) & mask;
        end else begin
          next_s.pos = (s.pos + 13'h0001) & mask;
        end
      end
    end
    // warning set wins.
    // Set is applied after the clear so an event in the clearing cycle is kept.
    if (limiting) begin
      next_s.warn = 1'b1;
    end
    // falling at zero.
    // Before the first sample the outputs rest at the idle level.
    if (next_s.primed) begin
      next_s.phaseA = decA ^ next_s.output_invert;
      next_s.phaseB = decB ^ next_s.output_invert;
      next_s.index  = decIndex ^ next_s.output_invert;
    end else begin
      next_s.phaseA = next_s.output_invert;
      next_s.phaseB = next_s.output_invert;
      next_s.index  = next_s.output_invert;
    end
  end

  // State register; everything freezes while the clock enable is low.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s                    <= '0;
      s.resCode            <= qenc_pkg::RES_RESET;
      s.idxMode            <= qenc_pkg::IDX_RESET;
      s.edge_slew_interval <= qenc_pkg::SLEW_RESET;
      s.hystWin            <= qenc_pkg::HYSTWIN_RESET;
    end else if (clkEn) begin
      s <= next_s;
    end
  end

  // Outputs come straight from the state register.
  assign regRdata           = s.rdata;
  assign quadA              = s.phaseA;
  assign quadB              = s.phaseB;
  assign quadIndex          = s.index;
  assign hysteresisEnable   = s.hystEn;
  assign hysteresisWindow   = s.hystWin;
  assign slew_limit_warning = s.warn;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks on the outputs and their causes.

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  chk_gray_single: assert property (
    (clkEn && s.primed && slewOn && $past(s.primed) && $past(clkEn))
    |=> ($countones({quadA, quadB} ^ $past({quadA, quadB})) <= 1)
  ) else $error("Quadrature phases changed two bits in one step.");

  chk_slew_spacing: assert property (
    stepPulse |=> !stepPulse [*4]
  ) else $error("Slew steps closer than the minimum interval.");

  chk_warn_set: assert property (
    limiting |=> slew_limit_warning
  ) else $error("Limiting occurred without setting the warning.");

  chk_direct_track: assert property (
    (clkEn && s.primed && !slewOn && diff != 13'h0000) |=> (s.pos == $past(target))
  ) else $error("Output did not follow the sample with limiting off.");

  chk_index_zero: assert property (
    (s.primed && s.pos == 13'h0000) |-> (quadIndex != s.output_invert)
  ) else $error("Index not active at the zero position.");

  chk_first_seed: assert property (
    (clkEn && !s.primed && sampleValid) |=> (s.primed && s.pos == $past(targetIn))
  ) else $error("First sample did not seed the output position.");

  chk_step_size: assert property (
    (stepPulse && !regWrite) |=> (((s.pos - $past(s.pos)) & mask) == 13'h0001
                                  || ((s.pos - $past(s.pos)) & mask) == mask)
  ) else $error("Slew step moved more than one state.");

  chk_status_read: assert property (
    (regRead && regAddr == qenc_pkg::OFF_STATUS && clkEn)
    |=> (regRdata[qenc_pkg::WARN_BIT] == $past(s.warn))
  ) else $error("Status read did not return the warning flag.");

  chk_read_once: assert property (
    (!regRead && clkEn) |=> (regRdata == 32'h0000_0000)
  ) else $error("Read data held beyond its one cycle.");

  cov_slew_step: cover property (stepPulse ##[5:200] stepPulse);
  cov_warn_set: cover property (!slew_limit_warning ##1 slew_limit_warning);
  cov_index_rise: cover property (s.primed && !quadIndex ##1 quadIndex);
  cov_reverse_step: cover property (stepPulse && backward);

endmodule

// File: slew_timer.sv
// Down counter that paces output edges while slew limiting is active.
`timescale 1ns/1ps
module slew_timer (
  input  wire logic                               sys_clk,
  input  wire logic                               rst,
  input  wire logic                               clkEn,
  input  wire logic                               start,
  input  wire logic [qenc_pkg::TIMER_W-1:0]       periodCycles,
  output logic                                    done
);

  typedef struct packed {
    logic [qenc_pkg::TIMER_W-1:0] count;
  } timer_state_type;

  timer_state_type s;
  timer_state_type next_s;

  // Loading period minus one puts the next permitted edge exactly one period later.
  always_comb begin
    next_s = s;
    if (start) begin
      next_s.count = periodCycles - 8'h01;
    end else if (s.count != 8'h00) begin
      next_s.count = s.count - 8'h01;
    end
  end

  // State register, frozen while the clock enable is low.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s <= '0;
    end else if (clkEn) begin
      s <= next_s;
    end
  end

  // Expiry is a level so a pending step can wait for it.
  assign done = (s.count == 8'h00);

endmodule

// File: tb_quadrature_encoder_output.sv
// Self-checking bench for the quadrature encoder output block.
`timescale 1ns/1ps
module tb_quadrature_encoder_output;
  typedef struct {
    logic [31:0]         cfg;
    qenc_pkg::angle_type raw;
    qenc_pkg::angle_type hyst;
    logic [2:0]          pins;
  } row_type;

  logic                        sys_clk;
  logic                        rst;
  logic                        clkEn;
  qenc_pkg::angle_type         rawAngle;
  qenc_pkg::angle_type         hystAngle;
  logic                        sampleValid;
  logic [qenc_pkg::ADDR_W-1:0] regAddr;
  logic [qenc_pkg::DATA_W-1:0] regWdata;
  logic                        regWrite;
  logic                        regRead;
  logic [qenc_pkg::DATA_W-1:0] regRdata;
  logic                        quadA;
  logic                        quadB;
  logic                        quadIndex;
  logic                        hystEn;
  logic [5:0]                  hystWin;
  logic                        slewWarn;
  logic                        armed;
  logic [15:0]                 stepCount;
  logic [15:0]                 badSteps;
  logic [15:0]                 lastGap;
  logic [15:0]                 indexRises;
  int                          err_count;
  int                          tests_run;
  int                          cycleCount;
  int                          p;
  int                          codes [0:2] = '{1, 8, 63};
  row_type                     rows [0:10];

  quadrature_encoder_output DUT (.sys_clk(sys_clk), .rst(rst), .clkEn(clkEn),
    .rawAngle(rawAngle), .hystAngle(hystAngle), .sampleValid(sampleValid),
    .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
    .regRdata(regRdata), .quadA(quadA), .quadB(quadB), .quadIndex(quadIndex),
    .hysteresisEnable(hystEn), .hysteresisWindow(hystWin),
    .slew_limit_warning(slewWarn));

  enc_receiver_model host (.sys_clk(sys_clk), .rst(rst), .armed(armed), .invert(1'b0),
    .quadA(quadA), .quadB(quadB), .quadIndex(quadIndex), .stepCount(stepCount),
    .badSteps(badSteps), .lastGap(lastGap), .indexRises(indexRises));

  //////////////////////////////////////////////////////////////////////////////
  // Compare tasks and the single closing point.
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_pins(input logic [2:0] got, input logic [2:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t pins got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic end_sim();
    $display("Comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // Bus and sample drivers: one-cycle strobes launched just after an edge.
  task automatic wr(input logic [7:0] addr, input logic [31:0] data);
    @(posedge sys_clk);
    regWrite <= 1'b1;
    regAddr  <= addr;
    regWdata <= data;
    @(posedge sys_clk);
    regWrite <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] addr, input logic [31:0] exp);
    @(posedge sys_clk);
    regRead <= 1'b1;
    regAddr <= addr;
    @(posedge sys_clk);
    regRead <= 1'b0;
    #1;
    chk_val(regRdata, exp);
  endtask

  task automatic sample(input qenc_pkg::angle_type raw, input qenc_pkg::angle_type hyst);
    @(posedge sys_clk);
    sampleValid <= 1'b1;
    rawAngle    <= raw;
    hystAngle   <= hyst;
    @(posedge sys_clk);
    sampleValid <= 1'b0;
  endtask

  // Sends a skipping sample at resolution 12 and waits the paced walk out.
  task automatic move(input logic [3:0] target, input logic [15:0] delta, input int steps);
    logic [15:0] base;
    base = stepCount;
    sample({target, 10'h000}, 14'h0000);
    repeat (2 + (steps - 1) * p + 3) @(posedge sys_clk);
    #1;
    chk_val({16'h0, 16'(stepCount - base)}, {16'h0, delta});
    chk_val({16'h0, lastGap}, 32'(p));
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // Free-running clock and a ceiling on the run length.
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    cycleCount <= cycleCount + 1;
    if (cycleCount == 3000) begin
      err_count++;
      end_sim();
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Main sequence: reset checks, table rows, then paced and awkward cases.
  initial begin
    rows = '{'{32'h0000000e, 14'h0000, 14'h0000, 3'h1}, '{32'h0000000e, 14'h1000, 14'h0, 3'h2},
             '{32'h0000000e, 14'h2000, 14'h0000, 3'h6}, '{32'h0000000e, 14'h3fff, 14'h0, 3'h4},
             '{32'h0000001e, 14'h1000, 14'h0000, 3'h3}, '{32'h0000003e, 14'h2000, 14'h0, 3'h7},
             '{32'h0000008e, 14'h0000, 14'h0000, 3'h6}, '{32'h0000004e, 14'h1000, 14'h0, 3'h4},
             '{32'h00000003, 14'h0006, 14'h0000, 3'h4}, '{32'h0000100e, 14'h0000, 14'h2000, 3'h6},
             '{32'h0000002e, 14'h1000, 14'h0000, 3'h3}};
    rst = 1'b1;
    clkEn = 1'b1;
    rawAngle = 14'h0000;
    hystAngle = 14'h0000;
    sampleValid = 1'b0;
    regAddr = 8'h00;
    regWdata = 32'h0;
    regWrite = 1'b0;
    regRead = 1'b0;
    armed = 1'b0;
    err_count = 0;
    tests_run = 0;
    cycleCount = 0;
    p = 0;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    #1;
    chk_pins({quadA, quadB, quadIndex}, 3'h0);
    rd(qenc_pkg::OFF_CONFIG, 32'h00080003);
    rd(qenc_pkg::OFF_STATUS, 32'h00000000);
    rd(8'h05, 32'h00000000);
    wr(qenc_pkg::OFF_HYST, 32'h0002a000);
    @(posedge sys_clk);
    #1;
    chk_val({26'h0, hystWin}, 32'h0000002a);
    // Each row sets resolution, index width, reversal, inversion or hysteresis.
    foreach (rows[i]) begin
      wr(qenc_pkg::OFF_CONFIG, rows[i].cfg);
      sample(rows[i].raw, rows[i].hyst);
      repeat (2) @(posedge sys_clk);
      #1;
      chk_pins({quadA, quadB, quadIndex}, rows[i].pins);
      chk_val({31'h0, hystEn}, {31'h0, rows[i].cfg[12]});
    end
    // Seed at state 13 of 16, then walk three states per slew code, wrapping zero first.
    wr(qenc_pkg::OFF_CONFIG, 32'h0000000c);
    sample(14'h3400, 14'h0000);
    repeat (4) @(posedge sys_clk);
    armed <= 1'b1;
    foreach (codes[i]) begin
      p = (qenc_pkg::SLEW_UNIT_NS * (codes[i] + 1) + qenc_pkg::CLK_PERIOD_NS - 1)
          / qenc_pkg::CLK_PERIOD_NS;
      wr(qenc_pkg::OFF_CONFIG, {10'h0, codes[i][5:0], 16'h000c});
      repeat (p + 4) @(posedge sys_clk);
      move(4'(16 + 3 * i), 16'h0003, 3);
    end
    chk_val({16'h0, indexRises}, 32'h00000001);
    chk_val({16'h0, badSteps}, 32'h00000000);
    // Half a turn backward through zero at the slowest pace, after the timer has run out.
    repeat (p) @(posedge sys_clk);
    move(4'he, 16'hfff8, 8);
    chk_val({16'h0, indexRises}, 32'h00000002);
    chk_val({31'h0, slewWarn}, 32'h00000001);
    rd(qenc_pkg::OFF_STATUS, 32'h000e0003);
    wr(qenc_pkg::OFF_STATUS, 32'h00000001);
    rd(qenc_pkg::OFF_STATUS, 32'h000e0002);
    // With the interval at zero a two-state skip lands at once, with no warning.
    wr(qenc_pkg::OFF_CONFIG, 32'h0000000c);
    sample(14'h0000, 14'h0000);
    repeat (2) @(posedge sys_clk);
    #1;
    chk_pins({quadA, quadB, quadIndex}, 3'h1);
    chk_val({31'h0, slewWarn}, 32'h00000000);
    // A write while the clock enable is low must not be taken.
    @(posedge sys_clk);
    clkEn <= 1'b0;
    wr(qenc_pkg::OFF_HYST, 32'h00000000);
    clkEn <= 1'b1;
    @(posedge sys_clk);
    #1;
    chk_val({26'h0, hystWin}, 32'h0000002a);
    end_sim();
  end
endmodule
